// *** rtl/ssq_sequencer.sv ***
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// RULE1: Constant zero/one patterns carry no address header, whole block constant.
// RULE2: Read run raises fail flag on any returned word differing from expected.
// RULE3: First mismatch only captures position, expected word and received word.
// RULE4: Write start goes idle to one-cycle load, then write-wait.
// RULE5: Write-wait with no stop moves to write-data once core ready.
// RULE6: Write-data drives 256 valid 128-bit beats, counting each beat.
// RULE7: Beat counter low byte at 255 moves to write-command.
// RULE8: Write-command with ready issues address, adds 8, back to write-wait.
// RULE9: Core must accept the write command right after a full burst.
// RULE10: One-cycle stop pulse is latched until the stop state begins.
// RULE11: Stop latch checked in write-wait; set means go to stop.
// RULE12: Write stop sends nothing, waits for core idle, then idle.
// RULE13: Read start goes idle to one-cycle load, then read-issue.
// RULE14: Read-issue requests every cycle ready is high; each adds 8.
// RULE15: Core drops ready when queue full, returns 4 KB per read.
// RULE16: Stop latch checked in read-issue; set means stop, no more requests.
// RULE17: Read stop waits all data returned and core idle, then idle.
// RULE18: Command valid comes from firmware in single mode, else sequencer.
// RULE19: Write and read data are 128 bits with own valid.
// RULE20: Address reaching disk maximum wraps to zero.
// RULE21: Sequencer busy low only in idle.
// RULE22: Pattern codes 0 inc,1 dec,2 zero,3 one,4 LFSR; separate verify bit.
// RULE23: Load clears fail flag, captures and counters.
// RULE24: Compare only with verify set; otherwise fail stays low.
module ssq_sequencer
    import ssq_pkg::*;
#(
    parameter int OUTSTANDING_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic host_cmd_ready,
    output logic host_cmd_valid,
    output logic [ADDR_W-1:0] host_cmd_address,
    input wire logic host_write_ready,
    output logic host_write_valid,
    output logic [DATA_W-1:0] host_write_word,
    input wire logic host_read_valid,
    input wire logic [DATA_W-1:0] host_read_word,
    input wire logic host_core_busy,
    input wire logic firmware_cmd_request,
    output logic sequencer_busy,
    output logic pattern_fail_flag
);

    if (OUTSTANDING_W < 6 || OUTSTANDING_W > 32) begin : g_check
        $error("OUTSTANDING_W out of range");
    end

    typedef struct packed {
        ssq_state_t state;
        logic mode_read;
        logic [2:0] pat_sel;
        logic verify;
        logic single_mode;
        logic [ADDR_W-1:0] start_addr;
        logic [ADDR_W-1:0] max_addr;
        logic [2:0] run_sel;
        logic run_verify;
        logic stop_latch;
        logic [ADDR_W-1:0] addr;
        logic [ADDR_W-1:0] wr_trn;
        logic [7:0] wr_beat;
        logic [31:0] wr_seed;
        logic [ADDR_W-1:0] rd_trn;
        logic [7:0] rd_beat;
        logic [31:0] rd_seed;
        logic [OUTSTANDING_W-1:0] outstanding;
        logic [31:0] cmd_count;
        logic [31:0] rd_total;
        logic fail;
        logic [31:0] fail_pos;
        logic [DATA_W-1:0] exp_word;
        logic [DATA_W-1:0] rcv_word;
        logic seq_req;
        logic cmd_valid;
        logic [ADDR_W-1:0] cmd_addr;
        logic wvalid;
        logic [DATA_W-1:0] wword;
        logic busy;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } ssq_regs_t;

    ssq_regs_t r_reg;
    ssq_regs_t r_next;

    // Next sequential address, wrapping at the disk end
    function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] a,
                                                    input logic [ADDR_W-1:0] m);
        logic [ADDR_W:0] s;
        s = {1'b0, a} + {1'b0, ADDR_STEP};
        return (s >= {1'b0, m}) ? '0 : s[ADDR_W-1:0];
    endfunction

    function automatic logic reg_mapped(input logic [PADDR_W-1:0] a);
        return (a[1:0] == 2'h0) && (a <= OFF_CMD_COUNT);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pattern generators: one for outgoing data, one for expected data

    ssq_pat_if wr_pat ();
    ssq_pat_if rd_pat ();

    ssq_pattern_gen u_wr_gen (
        .pat(wr_pat)
    );

    ssq_pattern_gen u_rd_gen (
        .pat(rd_pat)
    );

    assign wr_pat.sel = r_reg.run_sel;
    assign wr_pat.trn_addr = r_reg.wr_trn;
    assign wr_pat.beat = r_reg.wr_beat;
    assign wr_pat.seed = r_reg.wr_seed;
    assign rd_pat.sel = r_reg.run_sel;
    assign rd_pat.trn_addr = r_reg.rd_trn;
    assign rd_pat.beat = r_reg.rd_beat;
    assign rd_pat.seed = r_reg.rd_seed;

    ////////////////////////////////////////////////////////////////////////
    // APB decode

    logic apb_setup;
    logic apb_wr;
    logic wr_start;
    logic rd_start;
    logic stop_pulse;
    logic [31:0] rd_mux;

    assign apb_setup = psel && !penable;
    assign apb_wr = psel && penable && pwrite && r_reg.pready;
    assign wr_start = apb_wr && paddr == OFF_RUN_CTRL && pwdata[CTRL_WR_BIT];
    assign rd_start = apb_wr && paddr == OFF_RUN_CTRL && pwdata[CTRL_RD_BIT];
    assign stop_pulse = apb_wr && paddr == OFF_RUN_CTRL && pwdata[CTRL_STOP_BIT];

    always_comb begin
        case (paddr)
            OFF_PATTERN: rd_mux = {27'h0, r_reg.single_mode, r_reg.verify, r_reg.pat_sel};
            OFF_START_LO: rd_mux = r_reg.start_addr[31:0];
            OFF_START_HI: rd_mux = {16'h0000, r_reg.start_addr[47:32]};
            OFF_MAX_LO: rd_mux = r_reg.max_addr[31:0];
            OFF_MAX_HI: rd_mux = {16'h0000, r_reg.max_addr[47:32]};
            OFF_STATUS: rd_mux = {29'h0, r_reg.busy, r_reg.fail, host_core_busy};
            OFF_FAIL_POS: rd_mux = r_reg.fail_pos;
            8'h20, 8'h24, 8'h28, 8'h2C: rd_mux = r_reg.exp_word[paddr[3:2]*32 +: 32];
            8'h30, 8'h34, 8'h38, 8'h3C: rd_mux = r_reg.rcv_word[paddr[3:2]*32 +: 32];
            OFF_CMD_COUNT: rd_mux = r_reg.cmd_count;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic

    logic emit;
    logic cmd_inc;
    logic data_dec;

    always_comb begin
        r_next = r_reg;
        emit = 1'b0;
        cmd_inc = 1'b0;
        data_dec = 1'b0;
        r_next.pready = 1'b0;
        r_next.pslverr = 1'b0;
        r_next.seq_req = 1'b0;
        r_next.wvalid = 1'b0;

        // Zero-wait slave: answer registered from the setup cycle
        if (apb_setup) begin
            r_next.pready = 1'b1;
            r_next.pslverr = !reg_mapped(paddr);
            r_next.prdata = pwrite ? 32'h0000_0000 : rd_mux;
        end
        if (apb_wr) begin
            case (paddr)
                OFF_PATTERN: begin
                    r_next.pat_sel = pwdata[PAT_SEL_LSB +: 3]; // RULE22
                    r_next.verify = pwdata[PAT_VERIFY_BIT]; // RULE22
                    r_next.single_mode = pwdata[PAT_SINGLE_BIT];
                end
                OFF_START_LO: r_next.start_addr[31:0] = pwdata;
                OFF_START_HI: r_next.start_addr[47:32] = pwdata[15:0];
                OFF_MAX_LO: r_next.max_addr[31:0] = pwdata;
                OFF_MAX_HI: r_next.max_addr[47:32] = pwdata[15:0];
                default: ;
            endcase
        end

        case (r_reg.state)
            ST_IDLE: begin
                if (wr_start) begin
                    r_next.state = ST_LOAD; // RULE4
                    r_next.mode_read = 1'b0;
                end else if (rd_start) begin
                    r_next.state = ST_LOAD; // RULE13
                    r_next.mode_read = 1'b1;
                end
            end
            ST_LOAD: begin
                // Clearing here keeps results from a previous run out of this one
                r_next.addr = r_reg.start_addr;
                r_next.wr_trn = r_reg.start_addr;
                r_next.rd_trn = r_reg.start_addr;
                r_next.wr_beat = 8'h00;
                r_next.rd_beat = 8'h00;
                r_next.wr_seed = LFSR_SEED;
                r_next.rd_seed = LFSR_SEED;
                r_next.outstanding = '0; // RULE23
                r_next.cmd_count = 32'h0000_0000; // RULE23
                r_next.rd_total = 32'h0000_0000; // RULE23
                r_next.fail = 1'b0; // RULE23
                r_next.fail_pos = 32'h0000_0000; // RULE23
                r_next.exp_word = '0; // RULE23
                r_next.rcv_word = '0; // RULE23
                r_next.run_sel = r_reg.pat_sel;
                r_next.run_verify = r_reg.verify;
                r_next.state = r_reg.mode_read ? ST_RD_ISSUE : ST_WR_WAIT; // RULE4 RULE13
            end
            ST_WR_WAIT: begin
                if (r_reg.stop_latch) begin
                    r_next.state = ST_STOP; // RULE11
                end else if (host_write_ready) begin
                    r_next.state = ST_WR_DATA; // RULE5
                    emit = 1'b1;
                end
            end
            ST_WR_DATA: begin
                emit = 1'b1; // RULE6
                if (r_reg.wr_beat == BEAT_LAST) begin
                    r_next.state = ST_WR_CMD; // RULE7
                end
            end
            ST_WR_CMD: begin
                // Stays here only if the core breaks its side of the burst handshake
                if (host_cmd_ready) begin // RULE9
                    r_next.seq_req = 1'b1; // RULE8
                    r_next.cmd_addr = r_reg.addr;
                    r_next.addr = step_addr(r_reg.addr, r_reg.max_addr); // RULE8 RULE20
                    r_next.wr_trn = step_addr(r_reg.wr_trn, r_reg.max_addr);
                    r_next.cmd_count = r_reg.cmd_count + 32'h0000_0001;
                    r_next.state = ST_WR_WAIT;
                end
            end
            ST_RD_ISSUE: begin
                if (r_reg.stop_latch) begin
                    r_next.state = ST_STOP; // RULE16
                end else if (host_cmd_ready) begin // RULE15
                    r_next.seq_req = 1'b1; // RULE14
                    r_next.cmd_addr = r_reg.addr;
                    r_next.addr = step_addr(r_reg.addr, r_reg.max_addr); // RULE14 RULE20
                    cmd_inc = 1'b1;
                end
            end
            ST_STOP: begin
                if (!host_core_busy && (!r_reg.mode_read || r_reg.outstanding == '0)) begin
                    r_next.state = ST_IDLE; // RULE12 RULE17
                end
            end
            default: r_next.state = ST_IDLE;
        endcase

        // Outgoing data beat
        if (emit) begin
            r_next.wvalid = 1'b1; // RULE19
            r_next.wword = wr_pat.word;
            r_next.wr_beat = r_reg.wr_beat + 8'h01; // RULE6
            r_next.wr_seed = wr_pat.seed_next;
        end

        // Returned data runs independently of command issue
        if (host_read_valid && r_reg.mode_read && r_reg.state != ST_IDLE
                && r_reg.state != ST_LOAD) begin
            r_next.rd_beat = r_reg.rd_beat + 8'h01;
            r_next.rd_seed = rd_pat.seed_next;
            r_next.rd_total = r_reg.rd_total + 32'h0000_0001;
            if (r_reg.rd_beat == BEAT_LAST) begin
                r_next.rd_trn = step_addr(r_reg.rd_trn, r_reg.max_addr);
                r_next.cmd_count = r_reg.cmd_count + 32'h0000_0001;
                data_dec = 1'b1; // RULE17
            end
            if (r_reg.run_verify && host_read_word != rd_pat.word) begin // RULE24
                r_next.fail = 1'b1; // RULE2
                if (!r_reg.fail) begin
                    r_next.fail_pos = r_reg.rd_total; // RULE3
                    r_next.exp_word = rd_pat.word; // RULE3
                    r_next.rcv_word = host_read_word; // RULE3
                end
            end
        end

        case ({cmd_inc, data_dec})
            2'b10: r_next.outstanding = r_reg.outstanding + 1'b1;
            2'b01: r_next.outstanding = r_reg.outstanding - 1'b1;
            default: ;
        endcase

        // Set wins over the clear at stop entry, so no pulse is lost
        r_next.stop_latch = stop_pulse || (r_reg.stop_latch && r_next.state != ST_STOP); // RULE10
        r_next.busy = r_next.state != ST_IDLE; // RULE21
        r_next.cmd_valid = r_reg.single_mode ? firmware_cmd_request : r_next.seq_req; // RULE18
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '0;
            r_reg.max_addr <= MAX_ADDR_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    assign prdata = r_reg.prdata;
    assign pready = r_reg.pready;
    assign pslverr = r_reg.pslverr;
    assign host_cmd_valid = r_reg.cmd_valid;
    assign host_cmd_address = r_reg.cmd_addr;
    assign host_write_valid = r_reg.wvalid;
    assign host_write_word = r_reg.wword;
    assign sequencer_busy = r_reg.busy;
    assign pattern_fail_flag = r_reg.fail;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic [8:0] wv_run;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wv_run <= 9'h000;
        end else begin
            wv_run <= host_write_valid ? wv_run + 9'h001 : 9'h000;
        end
    end

    a_load_one_cycle: assert property (r_reg.state == ST_LOAD |=> // RULE4
        r_reg.state == ST_WR_WAIT || r_reg.state == ST_RD_ISSUE)
        else $error("load state did not last one cycle");
    a_burst_length: assert property ($fell(host_write_valid) |-> wv_run == 9'h100) // RULE6
        else $error("write burst not 256 beats");
    a_cmd_after_ready: assert property (r_reg.state == ST_WR_CMD && host_cmd_ready // RULE8
        |=> r_reg.seq_req && r_reg.state == ST_WR_WAIT)
        else $error("write command not issued on ready");
    a_addr_step_eight: assert property (r_reg.seq_req // RULE14
        && {1'b0, r_reg.cmd_addr} + {1'b0, ADDR_STEP} < {1'b0, r_reg.max_addr}
        |-> r_reg.addr == r_reg.cmd_addr + ADDR_STEP)
        else $error("address did not advance by 8");
    a_stop_latch_held: assert property (stop_pulse |=> r_reg.stop_latch // RULE10
        ##1 (r_reg.stop_latch || r_reg.state == ST_STOP))
        else $error("stop request lost");
    a_busy_idle: assert property (sequencer_busy == (r_reg.state != ST_IDLE)) // RULE21
        else $error("busy does not follow idle state");
    a_stop_quiet: assert property (r_reg.state == ST_STOP && $past(r_reg.state) == ST_STOP // RULE12
        |-> !r_reg.seq_req && !host_write_valid)
        else $error("request sent during stop");
    a_stop_exit: assert property ($past(r_reg.state) == ST_STOP && r_reg.state == ST_IDLE // RULE17
        |-> !$past(host_core_busy) && (!$past(r_reg.mode_read) || $past(r_reg.outstanding) == '0))
        else $error("left stop too early");
    a_fail_cause: assert property ($rose(pattern_fail_flag) // RULE24
        |-> $past(r_reg.run_verify) && $past(host_read_valid)
            && $past(host_read_word) != $past(rd_pat.word))
        else $error("fail raised without mismatch");
    a_first_capture: assert property (pattern_fail_flag && $past(pattern_fail_flag) // RULE3
        && r_reg.state != ST_LOAD |-> $stable(r_reg.rcv_word) && $stable(r_reg.fail_pos))
        else $error("capture overwritten after first failure");
    a_const_pattern: assert property (host_write_valid && r_reg.run_sel == PAT_ZERO // RULE1
        |-> host_write_word == '0)
        else $error("all-zero pattern carries data");

endmodule // ssq_sequencer

// *** rtl/ssq_pkg.sv ***
package ssq_pkg;

    // Host core side
    localparam int ADDR_W = 48;
    localparam int DATA_W = 128;
    localparam logic [ADDR_W-1:0] ADDR_STEP = 48'h0000_0000_0008;
    localparam logic [ADDR_W-1:0] MAX_ADDR_RST = 48'hFFFF_FFFF_FFFF;
    localparam logic [7:0] BEAT_LAST = 8'hFF;
    localparam logic [31:0] LFSR_SEED = 32'h0000_0001;

    // Pattern selector codes
    localparam logic [2:0] PAT_INC = 3'h0;
    localparam logic [2:0] PAT_DEC = 3'h1;
    localparam logic [2:0] PAT_ZERO = 3'h2;
    localparam logic [2:0] PAT_ONE = 3'h3;
    localparam logic [2:0] PAT_LFSR = 3'h4;

    // Register offsets (byte addresses)
    localparam int PADDR_W = 8;
    localparam logic [7:0] OFF_RUN_CTRL = 8'h00;
    localparam logic [7:0] OFF_PATTERN = 8'h04;
    localparam logic [7:0] OFF_START_LO = 8'h08;
    localparam logic [7:0] OFF_START_HI = 8'h0C;
    localparam logic [7:0] OFF_MAX_LO = 8'h10;
    localparam logic [7:0] OFF_MAX_HI = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    localparam logic [7:0] OFF_FAIL_POS = 8'h1C;
    localparam logic [7:0] OFF_EXP0 = 8'h20;
    localparam logic [7:0] OFF_RCV0 = 8'h30;
    localparam logic [7:0] OFF_CMD_COUNT = 8'h40;

    // Field positions
    localparam int CTRL_WR_BIT = 0;
    localparam int CTRL_RD_BIT = 1;
    localparam int CTRL_STOP_BIT = 2;
    localparam int PAT_SEL_LSB = 0;
    localparam int PAT_VERIFY_BIT = 3;
    localparam int PAT_SINGLE_BIT = 4;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LOAD,
        ST_WR_WAIT,
        ST_WR_DATA,
        ST_WR_CMD,
        ST_RD_ISSUE,
        ST_STOP
    } ssq_state_t;

endpackage

// *** rtl/ssq_pat_if.sv ***
`timescale 1ns/1ps
interface ssq_pat_if;
    import ssq_pkg::*;
    logic [2:0] sel;
    logic [ADDR_W-1:0] trn_addr;
    logic [7:0] beat;
    logic [31:0] seed;
    logic [DATA_W-1:0] word;
    logic [31:0] seed_next;

    modport gen (input sel, input trn_addr, input beat, input seed,
                 output word, output seed_next);
    modport user (output sel, output trn_addr, output beat, output seed,
                  input word, input seed_next);
endinterface

// *** rtl/ssq_pattern_gen.sv ***
`timescale 1ns/1ps
module ssq_pattern_gen
    import ssq_pkg::*;
(
    ssq_pat_if.gen pat
);

    // x^31 + x^21 + x + 1, one step
    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    logic [31:0] s;
    logic [31:0] inc;
    logic [31:0] dw;
    logic [DATA_W-1:0] w;

    // Look-ahead: four LFSR steps per beat so one 128-bit word per cycle
    always_comb begin
        s = pat.seed;
        inc = 32'h0000_0000;
        dw = 32'h0000_0000;
        w = '0;
        for (int i = 0; i < 4; i++) begin
            s = lfsr_step(s);
            inc = {pat.trn_addr[21:0], pat.beat, 2'(i)};
            case (pat.sel)
                PAT_INC: dw = inc;
                PAT_DEC: dw = ~inc;
                PAT_ZERO: dw = 32'h0000_0000;
                PAT_ONE: dw = 32'hFFFF_FFFF;
                PAT_LFSR: dw = s;
                default: dw = inc;
            endcase
            w[i*32 +: 32] = dw;
        end
        if (pat.beat == 8'h00 && pat.sel != PAT_ZERO && pat.sel != PAT_ONE) begin
            w[63:0] = {16'h0000, pat.trn_addr}; // RULE1
        end
        pat.word = w;
        pat.seed_next = s;
    end

endmodule // ssq_pattern_gen

// *** tb/ssq_host_model.sv ***
`timescale 1ns/1ps
module ssq_host_model
    import ssq_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    input wire logic [2:0] sel,
    input wire logic [15:0] bad_beat,
    input wire logic host_cmd_valid,
    input wire logic [ADDR_W-1:0] host_cmd_address,
    input wire logic host_write_valid,
    input wire logic [DATA_W-1:0] host_write_word,
    output logic host_cmd_ready,
    output logic host_write_ready,
    output logic host_read_valid,
    output logic [DATA_W-1:0] host_read_word,
    output logic host_core_busy,
    output int wr_beats,
    output int wr_bad
);
    logic [DATA_W-1:0] wbuf [256];
    logic [ADDR_W-1:0] rq [$];
    logic [DATA_W-1:0] w;
    logic [31:0] lf;
    int wp, rb, gb, tail;

    function automatic logic [DATA_W-1:0] pat(input logic [ADDR_W-1:0] a, input int b);
        logic [DATA_W-1:0] v;
        for (int i = 0; i < 4; i++) v[32*i +: 32] = {a[21:0], b[7:0], i[1:0]};
        if (sel == PAT_DEC) v = ~v;
        if (sel == PAT_LFSR) for (int i = 0; i < 4; i++) begin
            lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
            v[32*i +: 32] = lf;
        end
        if (b == 0) v[63:0] = {16'h0000, a};
        if (sel == PAT_ZERO) v = '0;
        if (sel == PAT_ONE) v = '1;
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {host_cmd_ready, host_write_ready, host_read_valid, host_core_busy} <= 4'h0;
            host_read_word <= '0;
            wr_beats <= 0;
            wr_bad <= 0;
            {wp, rb, gb, tail} = 128'h0;
            rq.delete();
        end else begin
            if (sel != PAT_LFSR) lf = LFSR_SEED;
            if (host_write_valid) begin
                wbuf[wp[7:0]] = host_write_word;
                wp++;
                wr_beats <= wr_beats + 1;
            end
            if (host_cmd_valid && wp == 256) begin
                for (int b = 0; b < 256; b++) begin
                    if (wbuf[b] !== pat(host_cmd_address, b)) wr_bad <= wr_bad + 1;
                end
                wp = 0;
                tail = 16;
            end else if (host_cmd_valid) begin
                rq.push_back(host_cmd_address);
            end
            host_read_valid <= rq.size() > 0;
            // Idle bus never keeps its last word
            w = ~host_read_word;
            if (rq.size() > 0) begin
                w = pat(rq[0], rb);
                if (gb == bad_beat) w[0] = ~w[0];
                rb++;
                gb++;
                if (rb == 256) begin
                    rb = 0;
                    tail = 4;
                    void'(rq.pop_front());
                end
            end else gb = 0;
            host_read_word <= w;
            if (tail > 0) tail--;
            // Margin of slots covers the sequencer's one-cycle command lag
            host_cmd_ready <= (wp == 256) || (!slow && rq.size() < 28);
            host_write_ready <= !slow && wp == 0;
            host_core_busy <= rq.size() > 0 || wp != 0 || tail > 0;
        end
    end
endmodule // ssq_host_model

// *** tb/ssq_sequencer_test.sv ***
`timescale 1ns/1ps
module ssq_sequencer_test;
    import ssq_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, slow, firmware_cmd_request, e;
    logic pready, pslverr, host_cmd_ready, host_cmd_valid, host_write_ready, host_write_valid;
    logic host_read_valid, host_core_busy, sequencer_busy, pattern_fail_flag;
    logic [PADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [ADDR_W-1:0] host_cmd_address;
    logic [DATA_W-1:0] host_write_word, host_read_word;
    logic [2:0] sel;
    logic [15:0] bad_beat;
    logic [ADDR_W-1:0] seen [$];
    int bad_count, n_tests, wr_beats, wr_bad, cyc;

    ssq_sequencer u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .host_cmd_ready, .host_cmd_valid, .host_cmd_address,
        .host_write_ready, .host_write_valid, .host_write_word, .host_read_valid,
        .host_read_word, .host_core_busy, .firmware_cmd_request, .sequencer_busy,
        .pattern_fail_flag);
    ssq_host_model u_host (.pclk, .presetn, .slow, .sel, .bad_beat, .host_cmd_valid,
        .host_cmd_address, .host_write_valid, .host_write_word, .host_cmd_ready,
        .host_write_ready, .host_read_valid, .host_read_word, .host_core_busy, .wr_beats,
        .wr_bad);

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (host_cmd_valid === 1'b1) seen.push_back(host_cmd_address);
        if (cyc == 60000) begin
            bad_count++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] x, input logic [31:0] g);
        n_tests++;
        if (g !== x) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", nm, x, g);
        end
    endtask
    // Setup edge, then hold everything until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input string nm);
        apb(1'b0, a, 32'h0000_0000);
        check(nm, x, q);
    endtask
    task automatic wait_idle();
        while (sequencer_busy !== 1'b0) @(posedge pclk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rd(OFF_STATUS, 32'h0000_0000, "status");
        rd(OFF_MAX_LO, 32'hFFFF_FFFF, "max");
        rd(8'h44, 32'h0000_0000, "unmapped");
        check("slverr", 32'h0000_0001, {31'h0, e});
        apb(1'b1, OFF_MAX_LO, 32'h0000_0110);
        apb(1'b1, OFF_MAX_HI, 32'h0000_0000);
        apb(1'b1, OFF_START_LO, 32'h0000_0100);
        $display("done regs");
    endtask
    task automatic t_write(input logic [2:0] s);
        int b0;
        b0 = wr_beats;
        sel <= s;
        apb(1'b1, OFF_PATTERN, {29'h0, s});
        seen.delete();
        apb(1'b1, OFF_RUN_CTRL, 32'h0000_0001);
        while (seen.size() < 3) @(posedge pclk);
        check("busy", 1, sequencer_busy);
        apb(1'b1, OFF_RUN_CTRL, 32'h0000_0004);
        wait_idle();
        check("words", 0, wr_bad);
        check("beats", 256 * seen.size(), wr_beats - b0);
        check("addr", 32'h0000_0108, seen[1][31:0]);
        check("wrap", 32'h0000_0000, seen[2][31:0]);
        $display("done write %0d", s);
    endtask
    task automatic t_read(input logic v, input logic [15:0] bb, input logic f);
        int n;
        sel <= PAT_INC;
        bad_beat <= bb;
        slow <= 1'b1;
        apb(1'b1, OFF_PATTERN, {28'h0, v, 3'h0});
        seen.delete();
        apb(1'b1, OFF_RUN_CTRL, 32'h0000_0002);
        repeat (50) @(posedge pclk);
        check("held", 0, seen.size());
        slow <= 1'b0;
        repeat (100) @(posedge pclk);
        apb(1'b1, OFF_RUN_CTRL, 32'h0000_0004);
        repeat (5) @(posedge pclk);
        n = seen.size();
        wait_idle();
        check("after stop", n, seen.size());
        check("fail", {31'h0, f}, {31'h0, pattern_fail_flag});
        rd(OFF_CMD_COUNT, seen.size(), "blocks");
        check("step", 32'h0000_0108, seen[1][31:0]);
        if (f) begin
            rd(OFF_FAIL_POS, 32'h0000_012C, "pos");
            rd(OFF_EXP0, {22'h000108, 8'h2C, 2'h0}, "exp");
            rd(OFF_RCV0, {22'h000108, 8'h2C, 2'h1}, "rcv");
        end
        $display("done read %0d %0d", v, f);
    endtask
    task automatic t_single();
        apb(1'b1, OFF_PATTERN, 32'h0000_0010);
        seen.delete();
        firmware_cmd_request <= 1'b1;
        @(posedge pclk);
        firmware_cmd_request <= 1'b0;
        repeat (4) @(posedge pclk);
        check("single", 1, seen.size());
        $display("done single");
    endtask

    initial begin
        {presetn, psel, penable, pwrite, slow, firmware_cmd_request} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        sel = 3'h0;
        bad_beat = 16'hFFFF;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        for (int s = 0; s < 5; s++) t_write(s[2:0]);
        t_read(1'b1, 16'h012C, 1'b1);
        t_read(1'b1, 16'hFFFF, 1'b0);
        t_read(1'b0, 16'h012C, 1'b0);
        t_single();
        wrap_up();
    end
endmodule // ssq_sequencer_test
